// ---- fpmu_top.sv ----
// float misc-ops unit: apb registers, decoder and datapath
// How it works
// - multiply-negate writes minus Rx times Ry to Rd; flags untouched.
// - integer to float, signed or unsigned, two roundings; flags untouched.
// - rounding bit zero means nearest even, one means toward zero.
// - signedness bit zero means unsigned, one means two's complement signed.
// - float to signed or unsigned integer with chosen rounding; flags untouched.
// - compare tests sign and magnitude of operands, writes no register, only flags change.
// - less sets C,N; greater clears; equal sets Z; unordered sets V.
// - check classifies NaN, infinity, denormal, exponent fd or fe; no write.
// - NaN sets C,N; infinity clears C,Z,N,V; denormal or big exponent sets Z.
// - flag codes let lo, gt, eq and ne branches test each class.
// - reciprocal approximation writes a seed for one over the operand.
// - reciprocal approximation also sets flags exactly like the check.
//
// The APB register port and the placing of the registers were decided locally.
module fpmu_top #(
    parameter int NREG = 16
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);

    logic [31:0]      gpr_q [NREG];
    logic [31:0]      instr_q;
    logic [4:0]       fl_q;
    logic [4:0]       fl_d;
    logic             go_q;
    logic             ill_q;
    logic             pready_q;
    logic [31:0]      prdata_q;
    logic             pslverr_q;

    // bus decode
    wire              acc = PSEL & PENABLE & pready_q;
    wire              bus_wr = acc & PWRITE;
    // one wait state after an instruction so reads see its result
    wire              pready_d = PSEL & ~pready_q & ~go_q;
    wire              sel_gpr = (PADDR < fpmu_pkg::A_GPR_END) && (PADDR[1:0] == 2'b00);
    wire              sel_ins = PADDR == fpmu_pkg::A_INSTR;
    wire              sel_fl = PADDR == fpmu_pkg::A_FLAGS;
    wire              sel_st = PADDR == fpmu_pkg::A_STAT;
    wire              hit = sel_gpr | sel_ins | sel_fl | sel_st;
    wire [3:0]        gidx = PADDR[5:2];

    wire [31:0]       rd_mux = sel_gpr ? gpr_q[gidx] :
                               sel_ins ? instr_q :
                               sel_fl  ? {27'h0, fl_q} :
                               sel_st  ? {31'h0, ill_q} : 32'h0;

    // instruction decode
    wire [15:0]       hi = instr_q[31:16];
    wire [3:0]        rd = instr_q[fpmu_pkg::RD_LSB +: 4];
    wire [3:0]        rx = instr_q[fpmu_pkg::RX_LSB +: 4];
    wire [3:0]        ry = instr_q[fpmu_pkg::RY_LSB +: 4];
    wire              is_mul = (hi == fpmu_pkg::OP_FNMUL) && (instr_q[15:12] == 4'h0);
    wire              is_own = hi[15:4] == fpmu_pkg::OP_OWN;
    wire              is_i2f = is_own && (hi[3:0] == fpmu_pkg::SUB_I2F);
    wire              is_f2i = is_own && (hi[3:0] == fpmu_pkg::SUB_F2I);
    wire              is_cmp = is_own && (hi[3:0] == fpmu_pkg::SUB_CMP);
    wire              is_chk = is_own && (hi[3:0] == fpmu_pkg::SUB_CHK);
    wire              is_rcp = is_own && (hi[3:0] == fpmu_pkg::SUB_RCP);
    wire              rnd_z = instr_q[fpmu_pkg::BIT_R];
    wire              sgn = instr_q[fpmu_pkg::BIT_S];
    wire              legal = is_mul | is_i2f | is_f2i | is_cmp | is_chk | is_rcp;
    wire              ex_wr = go_q & (is_mul | is_i2f | is_f2i | is_rcp);
    wire              ex_fl = go_q & (is_cmp | is_chk | is_rcp);

    wire [31:0]       a = gpr_q[rx];
    wire [31:0]       b = gpr_q[ry];

    logic             a_nan;
    logic             a_inf;
    logic             a_spec;
    logic             a_zero;
    logic             b_nan;
    logic             b_inf;
    logic             b_spec;
    logic             b_zero;

    fpmu_chk u_chk_a (
        .v       (a),
        .is_nan  (a_nan),
        .is_inf  (a_inf),
        .is_spec (a_spec),
        .is_zero (a_zero)
    );

    fpmu_chk u_chk_b (
        .v       (b),
        .is_nan  (b_nan),
        .is_inf  (b_inf),
        .is_spec (b_spec),
        .is_zero (b_zero)
    );

    // multiply-negate, denormal inputs and outputs flush to zero
    logic [31:0]      mul_r;
    always_comb begin : mul_p
        logic [47:0] p;
        logic [9:0]  e;
        logic [22:0] m;
        logic        g;
        logic        st;
        logic [23:0] mr;
        logic        sg;
        m = 23'h0;
        g = 1'b0;
        st = 1'b0;
        p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        e = 10'(a[30:23]) + 10'(b[30:23]) - fpmu_pkg::EXP_BIAS;
        sg = ~(a[31] ^ b[31]);
        if (p[47]) begin
            m = p[46:24];
            g = p[23];
            st = |p[22:0];
            e = e + 10'h001;
        end else begin
            m = p[45:23];
            g = p[22];
            st = |p[21:0];
        end
        mr = {1'b0, m} + 24'(g & (st | m[0]));
        if (mr[23]) begin
            e = e + 10'h001;
        end
        if (a_nan | b_nan | (a_inf & (a[30:23] == 8'h00)) | (b_inf & (a[30:23] == 8'h00))
            | (a_inf & (b[30:23] == 8'h00))) begin
            mul_r = fpmu_pkg::QNAN;
        end else if (a_inf | b_inf) begin
            mul_r = {sg, fpmu_pkg::EXP_MAX, 23'h0};
        end else if ((a[30:23] == 8'h00) || (b[30:23] == 8'h00) || e[9] || (e == 10'h000)) begin
            mul_r = {sg, 31'h0};
        end else if (e >= 10'(fpmu_pkg::EXP_MAX)) begin
            mul_r = {sg, fpmu_pkg::EXP_MAX, 23'h0};
        end else begin
            mul_r = {sg, e[7:0], mr[22:0]};
        end
    end

    // integer to float
    logic [31:0]      i2f_r;
    always_comb begin : i2f_p
        logic        neg;
        logic [31:0] mag;
        logic [4:0]  lz;
        logic [31:0] nm;
        logic [23:0] mr;
        logic        inc;
        neg = sgn & b[31];
        mag = neg ? -b : b;
        lz = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                lz = 5'(31 - i);
            end
        end
        nm = mag << lz;
        inc = ~rnd_z & nm[7] & ((|nm[6:0]) | nm[8]);
        mr = {1'b0, nm[30:8]} + 24'(inc);
        if (mag == 32'h0) begin
            i2f_r = 32'h0;
        end else begin
            i2f_r = {neg, fpmu_pkg::I2F_EXP0 - 8'(lz) + 8'(mr[23]), mr[22:0]};
        end
    end

    // float to integer, saturating at the ends of the range
    logic [31:0]      f2i_r;
    always_comb begin : f2i_p
        logic [7:0]  ea;
        logic [63:0] x;
        logic [32:0] mg;
        logic        big;
        ea = b[30:23];
        x = 64'h0;
        if ((ea >= fpmu_pkg::F2I_LO) && (ea <= fpmu_pkg::F2I_HI)) begin
            x = 64'({1'b1, b[22:0]}) << (ea - fpmu_pkg::F2I_LO);
        end
        mg = {1'b0, x[63:32]} + 33'(~rnd_z & x[31] & ((|x[30:0]) | x[32]));
        big = ea > fpmu_pkg::F2I_HI;
        if (b_nan) begin
            f2i_r = sgn ? fpmu_pkg::S_MAX : fpmu_pkg::U_MAX;
        end else if (sgn) begin
            if (b[31]) begin
                f2i_r = (big || (mg > 33'(fpmu_pkg::S_MIN))) ? fpmu_pkg::S_MIN : -mg[31:0];
            end else begin
                f2i_r = (big || (mg > 33'(fpmu_pkg::S_MAX))) ? fpmu_pkg::S_MAX : mg[31:0];
            end
        end else if (b[31]) begin
            f2i_r = 32'h0;
        end else begin
            f2i_r = (big || mg[32]) ? fpmu_pkg::U_MAX : mg[31:0];
        end
    end

    // compare by sign and magnitude; both zeros are equal
    wire              unord = a_nan | b_nan;
    wire              both0 = (a[30:0] == 31'h0) && (b[30:0] == 31'h0);
    wire              c_eq = both0 || (a == b);
    wire              c_lt = (a[31] != b[31]) ? a[31] :
                             a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);

    // reciprocal seed by integer subtract from a magic constant
    wire [31:0]       rcp_r = b_nan ? fpmu_pkg::QNAN :
                              b_inf ? {b[31], 31'h0} :
                              (b[30:23] == 8'h00) ? {b[31], fpmu_pkg::EXP_MAX, 23'h0} :
                              (b[30:23] >= fpmu_pkg::EXP_BIG1) ? {b[31], 31'h0} :
                              {b[31], fpmu_pkg::RCP_SEED[30:0] - b[30:0]};

    wire [31:0]       res = is_mul ? mul_r :
                            is_i2f ? i2f_r :
                            is_f2i ? f2i_r : rcp_r;

    // flag encoding; saturation bit is never touched here
    always_comb begin
        fl_d = fl_q;
        fl_d[fpmu_pkg::F_C] = 1'b0;
        fl_d[fpmu_pkg::F_N] = 1'b0;
        fl_d[fpmu_pkg::F_V] = 1'b0;
        fl_d[fpmu_pkg::F_Z] = 1'b0;
        if (is_cmp) begin
            if (unord) begin
                fl_d[fpmu_pkg::F_V] = 1'b1;
            end else if (c_eq) begin
                fl_d[fpmu_pkg::F_Z] = 1'b1;
            end else if (c_lt) begin
                fl_d[fpmu_pkg::F_C] = 1'b1;
                fl_d[fpmu_pkg::F_N] = 1'b1;
            end
        end else if (b_nan) begin
            fl_d[fpmu_pkg::F_C] = 1'b1;
            fl_d[fpmu_pkg::F_N] = 1'b1;
        end else if (b_inf) begin
            fl_d = fl_q & 5'h10;
        end else if (b_spec) begin
            fl_d[fpmu_pkg::F_Z] = 1'b1;
        end else begin
            // ordinary value: no predicate holds, so lo and eq both fail
            fl_d[fpmu_pkg::F_V] = 1'b1;
        end
    end

    // register file, one flop word per entry
    for (genvar gi = 0; gi < NREG; gi++) begin : g_gpr
        always_ff @(posedge SYS_CLK or negedge RST_B) begin
            if (!RST_B) begin
                gpr_q[gi] <= fpmu_pkg::GPR_RST;
            end else if (bus_wr && sel_gpr && (gidx == 4'(gi))) begin
                gpr_q[gi] <= PWDATA;
            end else if (ex_wr && (rd == 4'(gi))) begin
                gpr_q[gi] <= res;
            end
        end
    end

    // instruction, flags and status
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            instr_q <= fpmu_pkg::INSTR_RST;
            go_q <= 1'b0;
            fl_q <= fpmu_pkg::FLAGS_RST;
            ill_q <= 1'b0;
        end else begin
            go_q <= bus_wr & sel_ins;
            if (bus_wr && sel_ins) begin
                instr_q <= PWDATA;
            end
            if (bus_wr && sel_fl) begin
                fl_q <= PWDATA[fpmu_pkg::FL_W-1:0];
            end else if (ex_fl) begin
                fl_q <= fl_d;
            end
            if (go_q) begin
                ill_q <= ~legal;
            end
        end
    end

    // apb answer
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pready_d & ~hit;
            if (pready_d) begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign PREADY = pready_q;
    assign PRDATA = prdata_q;
    assign PSLVERR = pslverr_q;

endmodule : fpmu_top

// ---- fpmu_pkg.sv ----
// constants shared by the float misc-ops unit
package fpmu_pkg;

    // apb word offsets
    localparam logic [11:0] A_GPR_END = 12'h040;
    localparam logic [11:0] A_INSTR   = 12'h040;
    localparam logic [11:0] A_FLAGS   = 12'h044;
    localparam logic [11:0] A_STAT    = 12'h048;

    // flag positions and reset values
    localparam int          F_C       = 0;
    localparam int          F_Z       = 1;
    localparam int          F_N       = 2;
    localparam int          F_V       = 3;
    localparam int          F_Q       = 4;
    localparam int          FL_W      = 5;
    localparam logic [4:0]  FLAGS_RST = 5'h00;
    localparam logic [31:0] INSTR_RST = 32'h0;
    localparam logic [31:0] GPR_RST   = 32'h0;
    localparam int          ST_ILL    = 0;

    // instruction word layout
    localparam logic [15:0] OP_FNMUL  = 16'he5a3;
    localparam logic [11:0] OP_OWN    = 12'he5b;
    localparam logic [3:0]  SUB_I2F   = 4'h0;
    localparam logic [3:0]  SUB_F2I   = 4'h1;
    localparam logic [3:0]  SUB_CMP   = 4'h2;
    localparam logic [3:0]  SUB_CHK   = 4'h3;
    localparam logic [3:0]  SUB_RCP   = 4'h4;
    localparam int          BIT_R     = 15;
    localparam int          BIT_S     = 14;
    localparam int          RD_LSB    = 8;
    localparam int          RX_LSB    = 4;
    localparam int          RY_LSB    = 0;

    // float format figures
    localparam logic [7:0]  EXP_BIG1  = 8'hfd;
    localparam logic [7:0]  EXP_BIG2  = 8'hfe;
    localparam logic [7:0]  EXP_MAX   = 8'hff;
    localparam logic [9:0]  EXP_BIAS  = 10'h07f;
    localparam logic [7:0]  I2F_EXP0  = 8'h9e;
    localparam logic [7:0]  F2I_LO    = 8'h76;
    localparam logic [7:0]  F2I_HI    = 8'h9e;
    localparam logic [31:0] QNAN      = 32'h7fc00000;
    localparam logic [31:0] RCP_SEED  = 32'h7ef311c3;
    localparam logic [31:0] S_MAX     = 32'h7fffffff;
    localparam logic [31:0] S_MIN     = 32'h80000000;
    localparam logic [31:0] U_MAX     = 32'hffffffff;

endpackage : fpmu_pkg

// ---- fpmu_chk.sv ----
// special-value classifier for one single-precision operand
module fpmu_chk (
    input  wire logic [31:0] v,
    output logic             is_nan,
    output logic             is_inf,
    output logic             is_spec,
    output logic             is_zero
);
    wire [7:0]  e = v[30:23];
    wire [22:0] m = v[22:0];
    wire        e_max = e == fpmu_pkg::EXP_MAX;
    wire        e_nil = e == 8'h00;
    wire        big = (e == fpmu_pkg::EXP_BIG1) || (e == fpmu_pkg::EXP_BIG2);

    assign is_nan  = e_max & (m != 23'h0);
    assign is_inf  = e_max & (m == 23'h0);
    assign is_spec = (e_nil & (m != 23'h0)) | big;
    assign is_zero = e_nil & (m == 23'h0);

endmodule : fpmu_chk

// ---- fpmu_checker.sv ----
// apb-side assertions for the float misc-ops unit
module fpmu_checker #(
    parameter int NREG = 16
) (
    input wire logic        SYS_CLK,
    input wire logic        RST_B,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    logic q_q;
    logic ill_q;
    wire  done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    wire  hit  = PADDR[1:0] == 2'h0 && (PADDR < 12'(4 * NREG) ||
                 PADDR inside {fpmu_pkg::A_INSTR, fpmu_pkg::A_FLAGS, fpmu_pkg::A_STAT});
    wire  fnm  = PWDATA[31:12] == {fpmu_pkg::OP_FNMUL, 4'h0};
    wire  own  = PWDATA[31:20] == fpmu_pkg::OP_OWN && PWDATA[19:16] <= fpmu_pkg::SUB_RCP;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    // shadows so reads of flags and status can be judged
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            q_q   <= 1'b0;
            ill_q <= 1'b0;
        end else if (done && PADDR == fpmu_pkg::A_FLAGS) begin
            q_q <= PWDATA[fpmu_pkg::F_Q];
        end else if (done && PADDR == fpmu_pkg::A_INSTR) begin
            ill_q <= !(fnm || own);
        end
    end

    property p_rdy_acc; PREADY |-> PSEL && PENABLE; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access phase");
    property p_rdy_one; PREADY |=> !PREADY; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
    property p_rdy_wait; PSEL && !PENABLE |-> ##[1:2] PREADY; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
    property p_err_map; PREADY |-> PSLVERR == !hit; endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
    property p_err_rd; PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0; endproperty
    a_err_rd: assert property (p_err_rd) else $error("unmapped read not zero");
    property p_q_keep; PREADY && !PWRITE && PADDR == fpmu_pkg::A_FLAGS |->
        PRDATA[fpmu_pkg::F_Q] == q_q && PRDATA[31:5] == 27'h0; endproperty
    a_q_keep: assert property (p_q_keep) else $error("saturation flag changed");
    property p_ill; PREADY && !PWRITE && PADDR == fpmu_pkg::A_STAT |-> PRDATA == {31'h0, ill_q}; endproperty
    a_ill: assert property (p_ill) else $error("illegal status wrong");
    property p_stat_wr; PREADY && PWRITE && PADDR == fpmu_pkg::A_STAT |-> !PSLVERR; endproperty
    a_stat_wr: assert property (p_stat_wr) else $error("status write flagged error");

    c_err: cover property (PREADY && PSLVERR);
    c_instr: cover property (PREADY && PWRITE && PADDR == fpmu_pkg::A_INSTR);
    c_ill: cover property (PREADY && !PWRITE && PADDR == fpmu_pkg::A_STAT && PRDATA[0]);
endmodule : fpmu_checker

bind fpmu_top fpmu_checker #(.NREG(NREG)) u_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR));

// ---- fpmu_core_model.sv ----
// apb master standing in for the core pipeline
module fpmu_core_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // no wait limit here: only the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : xfer
endmodule : fpmu_core_model

// ---- tb_fp_single_misc_ops_unit.sv ----
// self-checking bench for the float misc-ops unit
module tb_fp_single_misc_ops_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk  = 1'b0;
    logic        rst_b    = 1'b0;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          errors   = 0;
    int          compares = 0;
    int          cycles   = 0;

    always #20 sys_clk = ~sys_clk;

    fpmu_top #(.NREG(16)) dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    fpmu_core_model bus (.clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic acc(input string n, input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic e, input logic [31:0] x);
        logic [31:0] r;
        logic        s;
        bus.xfer(w, a, d, r, s);
        cmp("pslverr", {31'h0, e}, {31'h0, s});
        if (!w) cmp(n, x, r);
    endtask : acc

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc("write", 1'b1, a, d, 1'b0, 32'h0);
    endtask : wr

    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
        acc(n, 1'b0, a, 32'h0, 1'b0, x);
    endtask : rd

    function automatic logic [11:0] gr(input logic [3:0] i);
        return {6'h0, i, 2'b00};
    endfunction : gr

    // rs is {round, signed}; bits 13:12 kept zero
    function automatic logic [31:0] own(input logic [3:0] s, input logic [1:0] rs, input logic [3:0] d,
                                        input logic [3:0] x, input logic [3:0] y);
        return {fpmu_pkg::OP_OWN, s, rs, 2'b00, d, x, y};
    endfunction : own

    task automatic conv(input logic [3:0] s, input logic [1:0] rs, input logic [31:0] v, input logic [31:0] x);
        wr(gr(4), v);
        wr(fpmu_pkg::A_INSTR, own(s, rs, 4'h5, 4'h0, 4'h4));
        rd("convert", gr(5), x);
    endtask : conv

    task automatic fcmp(input logic [31:0] a, input logic [31:0] b, input logic [4:0] f);
        wr(gr(6), a);
        wr(gr(7), b);
        wr(fpmu_pkg::A_INSTR, own(fpmu_pkg::SUB_CMP, 2'b00, 4'h6, 4'h6, 4'h7));
        rd("compare flags", fpmu_pkg::A_FLAGS, {27'h0, f});
        rd("compare rx", gr(6), a);
    endtask : fcmp

    // flags set to 10 between check and rcp so a stale value cannot pass except for infinity
    task automatic spec(input logic [31:0] v, input logic [4:0] f, input logic [31:0] x);
        wr(gr(9), v);
        wr(gr(10), 32'h12345678);
        wr(fpmu_pkg::A_INSTR, own(fpmu_pkg::SUB_CHK, 2'b00, 4'ha, 4'h0, 4'h9));
        rd("check flags", fpmu_pkg::A_FLAGS, {27'h0, f});
        rd("check no write", gr(10), 32'h12345678);
        wr(fpmu_pkg::A_FLAGS, 32'h10);
        wr(fpmu_pkg::A_INSTR, own(fpmu_pkg::SUB_RCP, 2'b00, 4'ha, 4'h0, 4'h9));
        rd("rcp flags", fpmu_pkg::A_FLAGS, {27'h0, f});
        rd("rcp value", gr(10), x);
    endtask : spec

    task automatic t_fnmul;
        rd("reset flags", fpmu_pkg::A_FLAGS, 32'h0);
        wr(gr(1), 32'h40000000);
        wr(gr(2), 32'h40400000);
        wr(fpmu_pkg::A_FLAGS, 32'h1f);
        wr(fpmu_pkg::A_INSTR, {fpmu_pkg::OP_FNMUL, 4'h0, 4'hf, 4'h1, 4'h2});
        rd("fnmul r15", gr(15), 32'hc0c00000);
        rd("fnmul flags", fpmu_pkg::A_FLAGS, 32'h1f);
        wr(gr(1), 32'hc0000000);
        wr(fpmu_pkg::A_INSTR, {fpmu_pkg::OP_FNMUL, 4'h0, 4'h0, 4'h1, 4'h2});
        rd("fnmul r0", gr(0), 32'h40c00000);
    endtask : t_fnmul

    task automatic t_i2f;
        wr(fpmu_pkg::A_FLAGS, 32'h0a);
        conv(fpmu_pkg::SUB_I2F, 2'b01, 32'hffffffff, 32'hbf800000);
        conv(fpmu_pkg::SUB_I2F, 2'b11, 32'hffffffff, 32'hbf800000);
        conv(fpmu_pkg::SUB_I2F, 2'b00, 32'hffffffff, 32'h4f800000);
        conv(fpmu_pkg::SUB_I2F, 2'b10, 32'hffffffff, 32'h4f7fffff);
        conv(fpmu_pkg::SUB_I2F, 2'b00, 32'h01000003, 32'h4b800002);
        conv(fpmu_pkg::SUB_I2F, 2'b10, 32'h01000003, 32'h4b800001);
        rd("i2f flags", fpmu_pkg::A_FLAGS, 32'h0a);
    endtask : t_i2f

    task automatic t_f2i;
        conv(fpmu_pkg::SUB_F2I, 2'b01, 32'h40600000, 32'h00000004);
        conv(fpmu_pkg::SUB_F2I, 2'b11, 32'h40600000, 32'h00000003);
        conv(fpmu_pkg::SUB_F2I, 2'b00, 32'h40600000, 32'h00000004);
        conv(fpmu_pkg::SUB_F2I, 2'b01, 32'hc0600000, 32'hfffffffc);
        conv(fpmu_pkg::SUB_F2I, 2'b11, 32'hc0600000, 32'hfffffffd);
        conv(fpmu_pkg::SUB_F2I, 2'b10, 32'hc0600000, 32'h00000000);
        rd("f2i flags", fpmu_pkg::A_FLAGS, 32'h0a);
    endtask : t_f2i

    task automatic t_cmp;
        wr(fpmu_pkg::A_FLAGS, 32'h10);
        fcmp(32'h3f800000, 32'h40000000, 5'h15);
        fcmp(32'h40000000, 32'h3f800000, 5'h10);
        fcmp(32'h00000000, 32'h80000000, 5'h12);
        fcmp(32'h7fc00000, 32'h3f800000, 5'h18);
    endtask : t_cmp

    task automatic t_spec;
        spec(32'h7fc00000, 5'h15, 32'h7fc00000);
        spec(32'hff800000, 5'h10, 32'h80000000);
        spec(32'h00000001, 5'h12, 32'h7f800000);
        spec(32'h7e800000, 5'h12, 32'h00000000);
        spec(32'h7f000000, 5'h12, 32'h00000000);
        spec(32'h40000000, 5'h18, 32'h3ef311c3);
    endtask : t_spec

    task automatic t_bad;
        wr(fpmu_pkg::A_INSTR, 32'he5a31123);
        rd("bad status", fpmu_pkg::A_STAT, 32'h1);
        rd("bad no write", gr(1), 32'hc0000000);
        wr(fpmu_pkg::A_INSTR, own(fpmu_pkg::SUB_CHK, 2'b00, 4'h0, 4'h0, 4'h0));
        rd("good status", fpmu_pkg::A_STAT, 32'h0);
        wr(fpmu_pkg::A_STAT, 32'h1);
        rd("status ro", fpmu_pkg::A_STAT, 32'h0);
        acc("unmapped", 1'b0, 12'h04c, 32'h0, 1'b1, 32'h0);
        acc("misaligned", 1'b1, 12'h002, 32'hffffffff, 1'b1, 32'h0);
        rd("misaligned no write", gr(0), 32'h40c00000);
    endtask : t_bad

    task automatic end_of_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // about 134 transfers of three cycles each
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_fnmul();
        t_i2f();
        t_f2i();
        t_cmp();
        t_spec();
        t_bad();
        end_of_test();
    end
endmodule : tb_fp_single_misc_ops_unit
